// file: hw/cis_core.sv
// Top: interrupt sources, vectoring and AXI4-Lite register slave
// Notes on behaviour
// R01: Pin edge polarity follows option bit six
// R02: Selected pin edge sets ext_pin_flag
// R03: ext_pin_enable low blocks pin request
// R04: Software clears ext_pin_flag before re-enabling
// R05: Pin wakes sleep only if enabled beforehand
// R06: After wake, vector only if global enable
// R07: Timer FFh to 00h sets overflow flag
// R08: Overflow request passes only when enabled
// R09: Any change on upper port pins sets flag
// R10: Port change request gated by its enable
// R11: Vector three cycles after event, instruction-independent
// R12: Only the return PC is saved
// R13: Flags set regardless of any enable
// R14: Global enable plus flagged source vectors at once
// R15: Vectoring clears global enable, pushes, loads 0004h
// R16: Return op sets global enable; reset clears
// R17: Flags sticky; new event beats software clear
`timescale 1ns/1ns
module cis_core
  import cis_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               nrst,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [ADDR_W-1:0]  s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // Sources
  input  wire logic               ext_irq_pin,
  input  wire logic [7:0]         tick_counter,
  input  wire logic [3:0]         second_io_port_hi,
  // CPU sequencer
  input  wire cis_cpu_in_t        cpu_in,
  output cis_cpu_out_t            cpu_out,
  output logic                    irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0]        icr_ff;        // irq_control_reg
  logic [7:0]        nxt_icr;
  logic [7:0]        opt_ff;        // Option register
  logic [7:0]        nxt_opt;
  logic [STS_W-1:0]  sts_ff;        // Sticky event status
  logic [STS_W-1:0]  nxt_sts;
  logic [STS_W-1:0]  msk_ff;        // Event mask
  logic [STS_W-1:0]  nxt_msk;
  logic              irq_ff;        // Level interrupt output
  logic              nxt_irq;
  logic [1:0]        wake_en_ff;    // Enables caught at sleep entry
  logic [1:0]        nxt_wake_en;
  logic              slept_ff;      // Sleep level one cycle ago
  logic              nxt_slept;
  cis_cpu_out_t      out_ff;        // CPU facing outputs
  cis_cpu_out_t      nxt_out;
  logic [7:0]        tmr_prev_ff;   // Timer value one cycle ago
  logic [7:0]        nxt_tmr_prev;
  logic              tmr_primed_ff; // Timer history valid
  logic              nxt_tmr_primed;
  // AXI state
  logic              aw_hold_ff;    // Write address captured
  logic              nxt_aw_hold;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [ADDR_W-1:0] nxt_aw_addr;
  logic              w_hold_ff;     // Write data captured
  logic              nxt_w_hold;
  logic [31:0]       w_data_ff;
  logic [31:0]       nxt_w_data;
  logic [3:0]        w_strb_ff;
  logic [3:0]        nxt_w_strb;
  logic              bvalid_ff;
  logic              nxt_bvalid;
  logic [1:0]        bresp_ff;
  logic [1:0]        nxt_bresp;
  logic              rvalid_ff;
  logic              nxt_rvalid;
  logic [31:0]       rdata_ff;
  logic [31:0]       nxt_rdata;
  logic [1:0]        rresp_ff;
  logic [1:0]        nxt_rresp;
  logic              awready_ff;
  logic              nxt_awready;
  logic              wready_ff;
  logic              nxt_wready;
  logic              arready_ff;
  logic              nxt_arready;
  // Combinational helpers
  logic              pin_rise;
  logic              pin_fall;
  logic [3:0]        port_rise;
  logic [3:0]        port_fall;
  logic              ev_int;        // Selected pin edge
  logic              ev_tmr;        // Timer rollover
  logic              ev_port;       // Upper port change
  logic              src_pend;      // Some source has flag and enable
  logic              vec_req;
  logic              vec_take;
  logic              wr_go;         // Write performed this cycle
  logic              wr_icr;
  logic              wr_opt;
  logic              wr_sts;
  logic              wr_msk;

  // Check that a byte address maps to a known register
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a == OFF_ICR) || (a == OFF_OPT) || (a == OFF_STS) || (a == OFF_MSK);
  endfunction

  // ****************************************************************
  // Event detection
  // ****************************************************************
  cis_chg_det #(.W(1)) u_pin_det (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .din     (ext_irq_pin),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  cis_chg_det #(.W(4)) u_port_det (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .din     (second_io_port_hi),
    .rise    (port_rise),
    .fall    (port_fall)
  );

  // Polarity chosen by option bit; software may flip it live
  assign ev_int  = opt_ff[BIT_EDGE] ? pin_rise : pin_fall; // R01
  assign ev_port = |(port_rise | port_fall); // R09
  // Rollover seen as top value followed by zero
  assign ev_tmr  = tmr_primed_ff && (tmr_prev_ff == TMR_TOP)
                   && (tick_counter == TMR_ZERO); // R07

  // Timer history
  always_comb begin
    nxt_tmr_prev   = tick_counter;
    nxt_tmr_primed = 1'b1;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tmr_prev_ff   <= TMR_ZERO;
      tmr_primed_ff <= 1'b0;
    end else begin
      tmr_prev_ff   <= nxt_tmr_prev;
      tmr_primed_ff <= nxt_tmr_primed;
    end
  end

  // ****************************************************************
  // Request gating and vectoring
  // ****************************************************************
  // Each source passes only through its own enable
  assign src_pend = (icr_ff[BIT_PFL] & icr_ff[BIT_PEN]) // R03
                  | (icr_ff[BIT_TFL] & icr_ff[BIT_TEN]) // R08
                  | (icr_ff[BIT_CFL] & icr_ff[BIT_CEN]); // R10
  // Global enable decides vectoring, also right after a wake
  assign vec_req  = icr_ff[BIT_GEN] & src_pend; // R14 R06

  cis_vec_seq #(.DLY(VEC_DLY)) u_vec (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .req     (vec_req),
    .take    (vec_take) // R11
  );

  // ****************************************************************
  // AXI4-Lite write decode
  // ****************************************************************
  assign wr_go  = aw_hold_ff && w_hold_ff && !bvalid_ff;
  assign wr_icr = wr_go && (aw_addr_ff == OFF_ICR) && w_strb_ff[0];
  assign wr_opt = wr_go && (aw_addr_ff == OFF_OPT) && w_strb_ff[0];
  assign wr_sts = wr_go && (aw_addr_ff == OFF_STS) && w_strb_ff[0];
  assign wr_msk = wr_go && (aw_addr_ff == OFF_MSK) && w_strb_ff[0];

  // ****************************************************************
  // Control and flag registers
  // ****************************************************************
  // Flags are set by events whatever the enables; a software write of
  // zero clears, but an event in the same cycle wins. Software is
  // expected to clear a flag before re-enabling its source.
  always_comb begin
    nxt_icr = icr_ff;
    nxt_opt = opt_ff;
    nxt_msk = msk_ff;
    if (wr_icr) begin
      nxt_icr = w_data_ff[7:0]; // R04
    end
    if (wr_opt) begin
      nxt_opt = w_data_ff[7:0];
    end
    if (wr_msk) begin
      nxt_msk = w_data_ff[STS_W-1:0];
    end
    // Events override any clear
    if (ev_int) begin
      nxt_icr[BIT_PFL] = 1'b1; // R02 R13 R17
    end
    if (ev_tmr) begin
      nxt_icr[BIT_TFL] = 1'b1; // R13 R17
    end
    if (ev_port) begin
      nxt_icr[BIT_CFL] = 1'b1; // R13 R17
    end
    // Return op re-enables; vectoring clears and takes priority
    if (cpu_in.ret_irq) begin
      nxt_icr[BIT_GEN] = 1'b1; // R16
    end
    if (vec_take) begin
      nxt_icr[BIT_GEN] = 1'b0; // R15
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      icr_ff <= ICR_RST; // R16
      opt_ff <= OPT_RST;
      msk_ff <= MSK_RST;
    end else begin
      icr_ff <= nxt_icr;
      opt_ff <= nxt_opt;
      msk_ff <= nxt_msk;
    end
  end

  // ****************************************************************
  // Sleep qualification and CPU outputs
  // ****************************************************************
  // Enables are caught on entry to sleep, so setting one while asleep
  // does not wake the core. Timer cannot wake: it stops in sleep.
  always_comb begin
    nxt_slept   = cpu_in.asleep;
    nxt_wake_en = wake_en_ff;
    if (cpu_in.asleep && !slept_ff) begin
      nxt_wake_en = {icr_ff[BIT_CEN], icr_ff[BIT_PEN]}; // R05
    end
    nxt_out          = out_ff;
    nxt_out.vec_addr = VEC_ADDR;
    nxt_out.vec_take = vec_take; // R15
    if (vec_take) begin
      nxt_out.ret_pc = cpu_in.pc; // R12
    end
    nxt_out.wake = cpu_in.asleep && slept_ff && !out_ff.wake
                   && ((icr_ff[BIT_PFL] && wake_en_ff[0])
                   ||  (icr_ff[BIT_CFL] && wake_en_ff[1])); // R05
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      slept_ff   <= 1'b0;
      wake_en_ff <= 2'h0;
      out_ff     <= '{vec_take: 1'b0, vec_addr: VEC_ADDR, ret_pc: '0, wake: 1'b0};
    end else begin
      slept_ff   <= nxt_slept;
      wake_en_ff <= nxt_wake_en;
      out_ff     <= nxt_out;
    end
  end

  assign cpu_out = out_ff;

  // ****************************************************************
  // Event status, mask and interrupt line
  // ****************************************************************
  // Write one clears; a new event in the same cycle keeps the bit
  always_comb begin
    nxt_sts = sts_ff;
    if (wr_sts) begin
      nxt_sts = sts_ff & ~w_data_ff[STS_W-1:0];
    end
    if (out_ff.vec_take) begin
      nxt_sts[STS_VEC] = 1'b1;
    end
    if (out_ff.wake) begin
      nxt_sts[STS_WAKE] = 1'b1;
    end
    nxt_irq = |(nxt_sts & nxt_msk);
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sts_ff <= STS_RST;
      irq_ff <= 1'b0;
    end else begin
      sts_ff <= nxt_sts;
      irq_ff <= nxt_irq;
    end
  end

  assign irq = irq_ff;

  // ****************************************************************
  // AXI4-Lite channels
  // ****************************************************************
  // Address and data are taken in either order; one write at a time
  always_comb begin
    nxt_aw_hold = aw_hold_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_hold  = w_hold_ff;
    nxt_w_data  = w_data_ff;
    nxt_w_strb  = w_strb_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    if (s_axi_awvalid && awready_ff) begin
      nxt_aw_hold = 1'b1;
      nxt_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_w_hold = 1'b1;
      nxt_w_data = s_axi_wdata;
      nxt_w_strb = s_axi_wstrb;
    end
    if (wr_go) begin
      nxt_aw_hold = 1'b0;
      nxt_w_hold  = 1'b0;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = is_mapped(aw_addr_ff) ? RESP_OK : RESP_ERR;
    end else if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    // Ready only while the holding slot is empty
    nxt_awready = !nxt_aw_hold && !nxt_bvalid;
    nxt_wready  = !nxt_w_hold && !nxt_bvalid;
  end

  // Reads answer one cycle after the address is taken
  always_comb begin
    nxt_rvalid  = rvalid_ff;
    nxt_rdata   = rdata_ff;
    nxt_rresp   = rresp_ff;
    if (s_axi_arvalid && arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = is_mapped(s_axi_araddr) ? RESP_OK : RESP_ERR;
      unique case (s_axi_araddr)
        OFF_ICR: nxt_rdata = {24'h0, icr_ff};
        OFF_OPT: nxt_rdata = {24'h0, opt_ff};
        OFF_STS: nxt_rdata = {30'h0, sts_ff};
        OFF_MSK: nxt_rdata = {30'h0, msk_ff};
        default: nxt_rdata = 32'h0;
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    nxt_arready = !nxt_rvalid;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      aw_hold_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_hold_ff  <= 1'b0;
      w_data_ff  <= 32'h0;
      w_strb_ff  <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OK;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0;
      rresp_ff   <= RESP_OK;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      arready_ff <= 1'b0;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      aw_addr_ff <= nxt_aw_addr;
      w_hold_ff  <= nxt_w_hold;
      w_data_ff  <= nxt_w_data;
      w_strb_ff  <= nxt_w_strb;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      arready_ff <= nxt_arready;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

endmodule

// file: hw/cis_pkg.sv
// Package: shared constants and carrier types for the interrupt source block
package cis_pkg;

  // ****************************************************************
  // Register map (byte addresses, one word each)
  // ****************************************************************
  localparam int         ADDR_W  = 8;     // Decoded address width
  localparam logic [7:0] OFF_ICR = 8'h00; // irq_control_reg
  localparam logic [7:0] OFF_OPT = 8'h04; // Option register
  localparam logic [7:0] OFF_STS = 8'h08; // Sticky event status, write one to clear
  localparam logic [7:0] OFF_MSK = 8'h0c; // Mask for the event status

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_GEN  = 7; // global_irq_enable
  localparam int BIT_TEN  = 5; // tick_overflow_enable
  localparam int BIT_PEN  = 4; // ext_pin_enable
  localparam int BIT_CEN  = 3; // upper_port_change_enable
  localparam int BIT_TFL  = 2; // tick_overflow_flag
  localparam int BIT_PFL  = 1; // ext_pin_flag
  localparam int BIT_CFL  = 0; // upper_port_change_flag
  localparam int BIT_EDGE = 6; // edge_polarity_select in option
  localparam int STS_VEC  = 0; // Event: vector taken
  localparam int STS_WAKE = 1; // Event: wake from sleep
  localparam int STS_W    = 2; // Width of status and mask

  // ****************************************************************
  // Reset values and fixed numbers
  // ****************************************************************
  localparam logic [7:0]        ICR_RST  = 8'h00;
  localparam logic [7:0]        OPT_RST  = 8'hff;
  localparam logic [STS_W-1:0]  STS_RST  = 2'h0;
  localparam logic [STS_W-1:0]  MSK_RST  = 2'h0;
  localparam int                PC_W     = 13; // Program counter width
  localparam logic [PC_W-1:0]   VEC_ADDR = 13'h0004; // Interrupt vector
  localparam logic [7:0]        TMR_TOP  = 8'hff; // Timer value before rollover
  localparam logic [7:0]        TMR_ZERO = 8'h00; // Timer value after rollover
  localparam int                VEC_LAT_TCY = 3; // Event to vector, in cycles
  localparam int                VEC_DLY  = VEC_LAT_TCY - 1; // Request to vector
  localparam logic [1:0]        RESP_OK  = 2'h0;
  localparam logic [1:0]        RESP_ERR = 2'h2;

  // ****************************************************************
  // Carrier types toward the CPU sequencer
  // ****************************************************************
  typedef struct packed {
    logic            asleep;    // CPU is in sleep
    logic            ret_irq;   // return_from_irq_op executed, one cycle
    logic [PC_W-1:0] pc;        // Address of the next instruction
  } cis_cpu_in_t;

  typedef struct packed {
    logic            vec_take;  // Load PC with vec_addr and push ret_pc
    logic [PC_W-1:0] vec_addr;  // Vector address
    logic [PC_W-1:0] ret_pc;    // Only context pushed on the stack
    logic            wake;      // Leave sleep, one cycle
  } cis_cpu_out_t;

endpackage

// file: hw/cis_chg_det.sv
// Module: per-bit change detector with rise and fall outputs
`timescale 1ns/1ns
module cis_chg_det
  import cis_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  logic [W-1:0] prev_ff;     // Last sampled level
  logic [W-1:0] nxt_prev;
  logic         primed_ff;   // Low until the first sample is held
  logic         nxt_primed;

  // Next state: track input, arm after first sample so reset gives no false edge
  always_comb begin
    nxt_prev   = din;
    nxt_primed = 1'b1;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      prev_ff   <= '0;
      primed_ff <= 1'b0;
    end else begin
      prev_ff   <= nxt_prev;
      primed_ff <= nxt_primed;
    end
  end

  // Edges as seen this cycle
  assign rise = primed_ff ? (din & ~prev_ff) : '0;
  assign fall = primed_ff ? (~din & prev_ff) : '0;

endmodule

// file: hw/cis_vec_seq.sv
// Module: vectoring delay, fires once a request has stood the fixed latency
`timescale 1ns/1ns
module cis_vec_seq
  import cis_pkg::*;
#(
  parameter int DLY = VEC_DLY
) (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic req,
  output logic      take
);

  logic [3:0] cnt_ff;     // Cycles the request has stood
  logic [3:0] nxt_cnt;
  logic       take_ff;    // One-cycle vector pulse
  logic       nxt_take;

  // Count does not look at the instruction, so one and two cycle
  // instructions see the same latency
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_take = 1'b0;
    if (!req) begin
      nxt_cnt = '0;
    end else if (cnt_ff < 4'(DLY - 1)) begin
      nxt_cnt = cnt_ff + 4'h1;
    end else begin
      nxt_take = !take_ff;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_ff  <= '0;
      take_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      take_ff <= nxt_take;
    end
  end

  assign take = take_ff;

endmodule

// file: sim/cis_core_properties.sv
// Checker: port-level timing relations of the interrupt source block
`timescale 1ns/1ns
module cis_core_properties
  import cis_pkg::*;
(
  input wire logic         clk_sys,
  input wire logic         nrst,
  input wire logic         s_axi_awready,
  input wire logic         s_axi_wready,
  input wire logic [1:0]   s_axi_bresp,
  input wire logic         s_axi_bvalid,
  input wire logic         s_axi_bready,
  input wire logic         s_axi_arready,
  input wire logic [31:0]  s_axi_rdata,
  input wire logic         s_axi_rvalid,
  input wire logic         s_axi_rready,
  input wire cis_cpu_in_t  cpu_in,
  input wire cis_cpu_out_t cpu_out
);
  // ****
  // Assertions
  // ****
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Start of a vector, then quiet for the next two cycles
  sequence take_s;
    $rose(cpu_out.vec_take);
  endsequence
  sequence quiet_s;
    !cpu_out.vec_take [*2];
  endsequence
  vec_one_shot_a: assert property (take_s |=> quiet_s)
    else $error("vector pulse repeated");
  vec_addr_fix_a: assert property (take_s |-> cpu_out.vec_addr == VEC_ADDR)
    else $error("vector address wrong");
  ret_pc_cap_a: assert property (take_s |-> cpu_out.ret_pc == $past(cpu_in.pc))
    else $error("return address not captured");
  // Wake only leaves a real sleep, and only as a single pulse
  wake_asleep_a: assert property (cpu_out.wake |-> $past(cpu_in.asleep))
    else $error("wake while awake");
  wake_single_a: assert property (cpu_out.wake |=> !cpu_out.wake)
    else $error("wake pulse too long");
  // Bus answers stand until taken, and no new request is accepted meanwhile
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  w_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready while answering");
  r_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read ready while answering");
endmodule

// file: sim/cis_cpu_model.sv
// Partner: CPU sequencer model with program counter, sleep and return pulse
`timescale 1ns/1ns
module cis_cpu_model
  import cis_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire cis_cpu_out_t cpu_out,
  input  wire logic         go_sleep,
  input  wire logic         do_ret,
  output cis_cpu_in_t       cpu_in
);
  // ****
  // Sequencer state
  // ****
  cis_cpu_in_t cpu_ff;   // Registered view toward the block
  cis_cpu_in_t nxt_cpu;  // Next state
  // Wake wins over a sleep request; pc is frozen while asleep unless a vector loads it
  always_comb begin
    nxt_cpu = cpu_ff;
    nxt_cpu.ret_irq = do_ret;
    if (cpu_out.wake) begin
      nxt_cpu.asleep = 1'b0;
    end else if (go_sleep) begin
      nxt_cpu.asleep = 1'b1;
    end
    if (cpu_out.vec_take) begin
      nxt_cpu.pc = cpu_out.vec_addr;
    end else if (!cpu_ff.asleep) begin
      nxt_cpu.pc = cpu_ff.pc + 13'h1;
    end
  end
  // Register only
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cpu_ff <= '0;
    end else begin
      cpu_ff <= nxt_cpu;
    end
  end
  assign cpu_in = cpu_ff;
endmodule

// file: sim/testbench.sv
// Testbench: registers, pin, timer, port, vector and sleep scenarios
`timescale 1ns/1ns
module testbench
  import cis_pkg::*;
;
  // ****
  // Stimulus and observation
  // ****
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, tick_counter = 8'hfe;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf, second_io_port_hi = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic ext_irq_pin = 1'b0, go_sleep = 1'b0, do_ret = 1'b0;
  cis_cpu_in_t cpu_in;
  cis_cpu_out_t cpu_out;
  int err_total = 0, compares = 0, nv, nw;
  logic [PC_W-1:0] pl, pr, va;  // Pc before take, captured pc, vector
  always #25 clk_sys = ~clk_sys;
  cis_core DUT (.clk_sys, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_irq_pin,
    .tick_counter, .second_io_port_hi, .cpu_in, .cpu_out, .irq);
  cis_cpu_model CPU (.clk_sys, .nrst, .cpu_out, .go_sleep, .do_ret, .cpu_in);
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask
  // Write: both channels offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(nm, s_axi_rdata, e);
  endtask
  // Observe eight cycles; note first vector and first wake
  task watch;
    nv = 0;
    nw = 0;
    for (int i = 1; i < 9; i++) begin
      if (nv == 0) pl = cpu_in.pc;
      @(posedge clk_sys);
      #1;
      if (cpu_out.vec_take === 1'b1 && nv == 0) begin
        nv = i;
        pr = cpu_out.ret_pc;
        va = cpu_out.vec_addr;
      end
      if (cpu_out.wake === 1'b1 && nw == 0) nw = i;
    end
  endtask
  // Source event: 0 pin, 1 timer, 2 upper port
  task ev(input int k, input logic [7:0] v);
    @(posedge clk_sys);
    if (k == 0) ext_irq_pin <= v[0];
    else if (k == 1) tick_counter <= v;
    else second_io_port_hi <= v[3:0];
    watch;
  endtask
  task nap;
    @(posedge clk_sys);
    go_sleep <= 1'b1;
    @(posedge clk_sys);
    go_sleep <= 1'b0;
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog: whole sequence needs well under 1000 cycles
  initial begin
    #100000;
    err_total++;
    finish_test;
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rdc(OFF_ICR, 32'h00, "icr_rst");
    rdc(OFF_OPT, 32'hff, "opt_rst");
    rdc(OFF_STS, 32'h00, "sts_rst");
    rdc(OFF_MSK, 32'h00, "msk_rst");
    rdc(8'h10, 32'h00, "unmap_rd");
    chk("unmap_rresp", 32'(rs), 32'(RESP_ERR));
    wr(8'h10, 32'h5a);
    chk("unmap_bresp", 32'(rs), 32'(RESP_ERR));
    $display("test regs done");
    ev(0, 8'h01);
    rdc(OFF_ICR, 32'h02, "rise_flag");
    wr(OFF_ICR, 32'h00);
    ev(0, 8'h00);
    rdc(OFF_ICR, 32'h00, "fall_ignored");
    wr(OFF_OPT, 32'hbf);
    ev(0, 8'h01);
    rdc(OFF_ICR, 32'h00, "rise_ignored");
    ev(0, 8'h00);
    rdc(OFF_ICR, 32'h02, "fall_flag");
    wr(OFF_ICR, 32'h00);
    ev(1, 8'hff);
    rdc(OFF_ICR, 32'h00, "no_roll");
    ev(1, 8'h00);
    rdc(OFF_ICR, 32'h04, "roll_flag");
    ev(2, 8'h08);
    rdc(OFF_ICR, 32'h05, "port_flag");
    $display("test sources done");
    wr(OFF_OPT, 32'hff);
    wr(OFF_MSK, 32'h01);
    wr(OFF_ICR, 32'h80);
    ev(0, 8'h01);
    chk("no_vec_pin", 32'(nv), 32'h0);
    ev(1, 8'hff);
    ev(1, 8'h00);
    chk("no_vec_tick", 32'(nv), 32'h0);
    rdc(OFF_ICR, 32'h86, "flags_gie");
    wr(OFF_ICR, 32'h90);
    ev(0, 8'h00);
    chk("no_vec_fall", 32'(nv), 32'h0);
    ev(0, 8'h01);
    chk("vec_lat", 32'(nv == 3 || nv == 4), 32'h1);
    chk("ret_pc", 32'(pr), 32'(pl));
    chk("vec_addr", 32'(va), 32'(VEC_ADDR));
    chk("irq_on", 32'(irq), 32'h1);
    rdc(OFF_ICR, 32'h12, "gie_clr");
    rdc(OFF_STS, 32'h01, "sts_vec");
    wr(OFF_STS, 32'h01);
    rdc(OFF_STS, 32'h00, "sts_w1c");
    chk("irq_off", 32'(irq), 32'h0);
    wr(OFF_ICR, 32'h10);
    @(posedge clk_sys);
    do_ret <= 1'b1;
    @(posedge clk_sys);
    do_ret <= 1'b0;
    rdc(OFF_ICR, 32'h90, "gie_ret");
    wr(OFF_ICR, 32'h88);
    ev(2, 8'h00);
    chk("port_vec", 32'(nv == 3 || nv == 4), 32'h1);
    wr(OFF_STS, 32'h01);
    $display("test vector done");
    wr(OFF_ICR, 32'h08);
    nap;
    ev(2, 8'h01);
    chk("wake", 32'(nw != 0), 32'h1);
    chk("no_vec_gie", 32'(nv), 32'h0);
    rdc(OFF_STS, 32'h02, "sts_wake");
    wr(OFF_ICR, 32'h00);
    nap;
    wr(OFF_ICR, 32'h08);
    ev(2, 8'h00);
    chk("no_wake", 32'(nw), 32'h0);
    $display("test sleep done");
    finish_test;
  end
endmodule
bind cis_core cis_core_properties u_prop (.clk_sys, .nrst, .s_axi_awready, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .cpu_in, .cpu_out);
